// ==== hw/crcu_top.sv ====
// crc unit: control register, byte input port and result data port
`timescale 1ns/100ps
`default_nettype none
module crcu_top
    import crcu_pkg::*;
(
    input wire logic CLK_SYS, // system clock, 100 MHz
    input wire logic RST_N, // synchronous reset, active low
    input wire logic [7:0] SFR_ADDR, // special register address
    input wire logic SFR_WR, // write strobe, one cycle
    input wire logic SFR_RD, // read strobe, one cycle
    input wire logic [7:0] SFR_WDATA, // write data
    output logic [7:0] SFR_RDATA, // read data, registered
    output logic [31:0] CRC_RESULT // full result register
);

    ////////////////////////////////////////////////////////////////////////
    // state registers
    logic sel16_q; // poly_length_select
    logic sel16_d; // next poly_length_select
    logic val_q; // init_value_select
    logic val_d; // next init_value_select
    logic [1:0] ptr_q; // result_byte_pointer
    logic [1:0] ptr_d; // next result_byte_pointer
    logic [31:0] result_q; // crc accumulator
    logic [31:0] result_d; // next crc accumulator
    logic [7:0] rdata_q; // read data holding register
    logic [7:0] rdata_d; // next read data

    ////////////////////////////////////////////////////////////////////////
    // address decode
    wire hit_ctrl = (SFR_ADDR == ADDR_CTRL); // control selected
    wire hit_in = (SFR_ADDR == ADDR_DATA_IN); // input port selected
    wire hit_res = (SFR_ADDR == ADDR_RESULT); // result port selected

    // qualified accesses
    wire wr_ctrl = SFR_WR & hit_ctrl; // control write
    wire wr_in = SFR_WR & hit_in; // input byte write
    wire wr_res = SFR_WR & hit_res; // result byte write
    wire rd_ctrl = SFR_RD & hit_ctrl; // control read
    wire rd_res = SFR_RD & hit_res; // result byte read
    wire rd_any = SFR_RD; // any read, mapped or not

    ////////////////////////////////////////////////////////////////////////
    // control write fields; bits 7:5 are dropped here
    wire w_sel = SFR_WDATA[CTRL_SEL_BIT];
    wire w_init = SFR_WDATA[CTRL_INIT_BIT]; // load trigger
    wire w_val = SFR_WDATA[CTRL_VAL_BIT]; // set value choice
    wire [1:0] w_ptr = SFR_WDATA[CTRL_PTR_LSB +: 2]; // new pointer

    // initial value picked by the select bit in the same write
    wire [31:0] init_value = w_val ? INIT_ONES : INIT_ZEROS;

    // control read image; the trigger bit always reads zero
    wire [7:0] ctrl_image = {CTRL_UNUSED_RD, sel16_q, 1'h0, val_q,
                             ptr_q};

    ////////////////////////////////////////////////////////////////////////
    // input byte folded into the top byte of the active width
    wire [31:0] pre16 = {result_q[31:16], result_q[15:8] ^ SFR_WDATA,
                         result_q[7:0]};
    wire [31:0] pre32 = {result_q[31:24] ^ SFR_WDATA,
                         result_q[23:0]};
    wire [31:0] dividend = sel16_q ? pre16 : pre32;

    ////////////////////////////////////////////////////////////////////////
    // eight reduce steps chained in one cycle, so a byte is done before
    // the next access can see the accumulator
    wire [31:0] chain [0:BITS_PER_BYTE]; // accumulator between steps
    assign chain[0] = dividend;

    genvar g;
    generate
        for (g = 0; g < BITS_PER_BYTE; g = g + 1) begin : g_step
            crcu_bit_step u_step (
                .acc_in (chain[g]),
                .sel16 (sel16_q),
                .acc_out (chain[g+1])
            );
        end
    endgenerate

    wire [31:0] crc_next = chain[BITS_PER_BYTE];

    ////////////////////////////////////////////////////////////////////////
    // result byte lane access
    crcu_lane_if lane_bus (); // bundle to the lane selector

    assign lane_bus.result = result_q;
    assign lane_bus.ptr = ptr_q;
    assign lane_bus.sel16 = sel16_q;
    assign lane_bus.wr_byte = SFR_WDATA;

    crcu_byte_lane u_lane (
        .lane (lane_bus.lane)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state selection

    // mode and set value change only on control writes
    assign sel16_d = wr_ctrl ? w_sel : sel16_q;
    assign val_d = wr_ctrl ? w_val : val_q;

    // pointer: loaded by control write, advanced by each result port access
    wire ptr_bump = wr_res | rd_res; // one result port access
    wire [1:0] ptr_inc = ptr_q + PTR_STEP; // wraps from 3 to 0
    assign ptr_d = wr_ctrl ? w_ptr :
                   ptr_bump ? ptr_inc : ptr_q;

    // result: init load, byte update, or direct byte write
    wire do_init = wr_ctrl & w_init; // trigger written as one
    assign result_d = do_init ? init_value :
                      wr_in ? crc_next :
                      wr_res ? lane_bus.merged :
                      result_q;

    // read data: mapped registers, zero for any other read, held when idle
    assign rdata_d = rd_ctrl ? ctrl_image :
                     rd_res ? lane_bus.rd_byte :
                     rd_any ? RDATA_RESET :
                     rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sel16_q <= CTRL_RESET[CTRL_SEL_BIT];
            val_q <= CTRL_RESET[CTRL_VAL_BIT];
            ptr_q <= CTRL_RESET[CTRL_PTR_LSB +: 2];
        end else begin
            sel16_q <= sel16_d;
            val_q <= val_d;
            ptr_q <= ptr_d;
        end
    end

    // accumulator
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            result_q <= RESULT_RESET;
        end else begin
            result_q <= result_d;
        end
    end

    // read data register
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rdata_q <= RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign SFR_RDATA = rdata_q;
    assign CRC_RESULT = result_q;

endmodule // crcu_top
`default_nettype wire

// ==== hw/crcu_pkg.sv ====
// constants shared by the crc unit files
`default_nettype none
package crcu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // special function register addresses
    localparam logic [7:0] ADDR_CTRL = 8'hCE; // control register
    localparam logic [7:0] ADDR_DATA_IN = 8'hDD; // byte input port
    localparam logic [7:0] ADDR_RESULT = 8'hDE; // result data port

    ////////////////////////////////////////////////////////////////////////
    // control register field positions
    localparam int CTRL_SEL_BIT = 4; // poly_length_select
    localparam int CTRL_INIT_BIT = 3; // result_load_trigger
    localparam int CTRL_VAL_BIT = 2; // init_value_select
    localparam int CTRL_PTR_LSB = 0; // result_byte_pointer low bit
    localparam logic [2:0] CTRL_UNUSED_RD = 3'h0; // bits 7:5 image

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00; // control after reset
    localparam logic [31:0] RESULT_RESET = 32'h00000000; // result reset
    localparam logic [7:0] RDATA_RESET = 8'h00; // read data reset

    ////////////////////////////////////////////////////////////////////////
    // polynomials and initial values
    localparam logic [15:0] POLY16 = 16'h1021; // 16-bit generator
    localparam logic [31:0] POLY32 = 32'h04C11DB7; // 32-bit generator
    localparam logic [31:0] INIT_ZEROS = 32'h00000000; // set value zeros
    localparam logic [31:0] INIT_ONES = 32'hFFFFFFFF; // set value ones

    ////////////////////////////////////////////////////////////////////////
    // counts
    localparam int BITS_PER_BYTE = 8; // reduce steps per input byte
    localparam logic [1:0] PTR_STEP = 2'h1; // pointer advance per access

endpackage : crcu_pkg
`default_nettype wire

// ==== hw/crcu_lane_if.sv ====
// carrier between the crc core and its result byte lane selector
`timescale 1ns/100ps
`default_nettype none
interface crcu_lane_if;
    logic [31:0] result; // current crc result
    logic [1:0] ptr; // result byte pointer
    logic sel16; // high when 16-bit mode
    logic [7:0] wr_byte; // byte written to the result port
    logic [7:0] rd_byte; // byte addressed by the pointer
    logic [31:0] merged; // result with addressed byte replaced

    modport owner (
        output result,
        output ptr,
        output sel16,
        output wr_byte,
        input rd_byte,
        input merged
    );

    modport lane (
        input result,
        input ptr,
        input sel16,
        input wr_byte,
        output rd_byte,
        output merged
    );
endinterface : crcu_lane_if
`default_nettype wire

// ==== hw/crcu_bit_step.sv ====
// one conditional shift-and-reduce step of the crc accumulator
`timescale 1ns/100ps
`default_nettype none
module crcu_bit_step
    import crcu_pkg::*;
(
    input wire logic [31:0] acc_in, // accumulator before step
    input wire logic sel16, // high selects the 16-bit poly
    output logic [31:0] acc_out // accumulator after step
);
    // msb of the active width decides whether the poly is subtracted
    wire msb16 = acc_in[15]; // top bit, 16-bit mode
    wire msb32 = acc_in[31]; // top bit, 32-bit mode
    wire [15:0] shl16 = {acc_in[14:0], 1'h0}; // shifted low half
    wire [31:0] shl32 = {acc_in[30:0], 1'h0}; // shifted full word
    wire [15:0] red16 = msb16 ? (shl16 ^ POLY16) : shl16;
    wire [31:0] red32 = msb32 ? (shl32 ^ POLY32) : shl32;

    // upper half stays untouched while running 16-bit
    assign acc_out = sel16 ? {acc_in[31:16], red16} : red32;
endmodule // crcu_bit_step
`default_nettype wire

// ==== hw/crcu_byte_lane.sv ====
// picks and replaces the result byte that the pointer addresses
`timescale 1ns/100ps
`default_nettype none
module crcu_byte_lane (
    crcu_lane_if.lane lane // pointer, mode and result bundle
);
    // in 16-bit mode only pointer bit 0 matters
    wire [1:0] idx = lane.sel16 ? {1'h0, lane.ptr[0]} : lane.ptr;

    // read selection
    assign lane.rd_byte = lane.result[idx*8 +: 8];

    // write merge: only the addressed byte changes
    always_comb begin
        lane.merged = lane.result;
        lane.merged[idx*8 +: 8] = lane.wr_byte;
    end
endmodule // crcu_byte_lane
`default_nettype wire

// ==== testbench/crcu_props.sv ====
// concurrent checks on the crc unit top ports
`timescale 1ns/100ps
`default_nettype none
module crcu_props
    import crcu_pkg::*;
(
    input wire logic CLK_SYS, // system clock
    input wire logic RST_N, // sync reset, low
    input wire logic [7:0] SFR_ADDR, // register address
    input wire logic SFR_WR, // write strobe
    input wire logic SFR_RD, // read strobe
    input wire logic [7:0] SFR_WDATA, // write data
    input wire logic [7:0] SFR_RDATA, // read data
    input wire logic [31:0] CRC_RESULT // whole result
);
    ////////////////////////////////////////////////////////////////////////
    // strobe decode
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire logic ctl_wr = SFR_WR && (SFR_ADDR == ADDR_CTRL); // control write
    wire logic in_wr = SFR_WR && (SFR_ADDR == ADDR_DATA_IN); // input byte
    wire logic port_wr = SFR_WR && (SFR_ADDR == ADDR_RESULT); // result port
    logic sel16_q; // length select as last written

    // track the length select for the half-width check
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sel16_q <= 1'h0;
        end else if (ctl_wr) begin
            sel16_q <= SFR_WDATA[CTRL_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // properties
    chk_reset_clear: assert property (disable iff (1'h0)
        !RST_N |=> CRC_RESULT == RESULT_RESET && SFR_RDATA == RDATA_RESET)
        else $error("reset did not clear result or read data");
    chk_init_ones: assert property (
        ctl_wr && SFR_WDATA[CTRL_INIT_BIT] && SFR_WDATA[CTRL_VAL_BIT]
        |=> CRC_RESULT == INIT_ONES) else $error("ones load missing");
    chk_init_zeros: assert property (
        ctl_wr && SFR_WDATA[CTRL_INIT_BIT] && !SFR_WDATA[CTRL_VAL_BIT]
        |=> CRC_RESULT == INIT_ZEROS) else $error("zeros load missing");
    chk_ctrl_upper: assert property (
        SFR_RD && SFR_ADDR == ADDR_CTRL |=> SFR_RDATA[7:5] == CTRL_UNUSED_RD
        && !SFR_RDATA[CTRL_INIT_BIT]) else $error("control read not zero");
    chk_input_read: assert property (
        SFR_RD && SFR_ADDR == ADDR_DATA_IN |=> SFR_RDATA == 8'h00)
        else $error("input port read not zero");
    chk_rdata_hold: assert property (
        !SFR_RD |=> $stable(SFR_RDATA)) else $error("read data moved");
    chk_result_idle: assert property (
        !(ctl_wr || in_wr || port_wr) |=> $stable(CRC_RESULT))
        else $error("result changed without a write");
    chk_half_keep: assert property (
        in_wr && sel16_q |=> CRC_RESULT[31:16] == $past(CRC_RESULT[31:16]))
        else $error("16-bit update touched upper half");
endmodule // crcu_props
bind crcu_top crcu_props u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CRC_RESULT(CRC_RESULT));
`default_nettype wire

// ==== testbench/tb_crc16_crc32_unit.sv ====
// self-checking bench for the crc unit
`timescale 1ns/100ps
`default_nettype none
module tb_crc16_crc32_unit
    import crcu_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // stimulus table: op 0 write, 1 write and check, 2 read and check
    typedef struct packed {
        logic [1:0] op; // access kind
        logic [7:0] addr; // register address
        logic [7:0] data; // write data
        logic [31:0] exp; // expected result or read byte
    } crcu_row_t;
    localparam logic [7:0] ac = ADDR_CTRL; // control
    localparam logic [7:0] ai = ADDR_DATA_IN; // input byte
    localparam logic [7:0] ar = ADDR_RESULT; // result port
    localparam crcu_row_t rows [36] = '{
        '{2'h1, ac, 8'h1D, 32'hFFFFFFFF}, '{2'h1, ai, 8'h63, 32'hFFFFBD35},
        '{2'h2, ar, 8'h00, 32'h000000BD}, '{2'h2, ar, 8'h00, 32'h00000035},
        '{2'h2, ar, 8'h00, 32'h000000BD}, '{2'h2, ar, 8'h00, 32'h00000035},
        '{2'h2, ac, 8'h00, 32'h00000015}, '{2'h1, ac, 8'hFC, 32'hFFFFFFFF},
        '{2'h0, ai, 8'hAA, 32'h00000000}, '{2'h0, ai, 8'hBB, 32'h00000000},
        '{2'h1, ai, 8'hCC, 32'hFFFF6CF6}, '{2'h2, ac, 8'h00, 32'h00000014},
        '{2'h1, ac, 8'h1C, 32'hFFFFFFFF}, '{2'h0, ai, 8'h00, 32'h00000000},
        '{2'h0, ai, 8'h00, 32'h00000000}, '{2'h0, ai, 8'hAA, 32'h00000000},
        '{2'h0, ai, 8'hBB, 32'h00000000}, '{2'h1, ai, 8'hCC, 32'hFFFFB166},
        '{2'h1, ac, 8'h08, 32'h00000000}, '{2'h1, ai, 8'h01, 32'h04C11DB7},
        '{2'h2, ar, 8'h00, 32'h000000B7}, '{2'h2, ar, 8'h00, 32'h0000001D},
        '{2'h2, ar, 8'h00, 32'h000000C1}, '{2'h2, ar, 8'h00, 32'h00000004},
        '{2'h1, ar, 8'h5A, 32'h04C11D5A}, '{2'h2, ar, 8'h00, 32'h0000001D},
        '{2'h2, ai, 8'h00, 32'h00000000}, '{2'h2, ar, 8'h00, 32'h000000C1},
        '{2'h2, 8'h00, 8'h00, 32'h00000000}, '{2'h1, ac, 8'h04, 32'h04C11D5A},
        '{2'h1, ac, 8'h0C, 32'hFFFFFFFF}, '{2'h2, ac, 8'h00, 32'h00000004},
        '{2'h1, 8'h00, 8'hA5, 32'hFFFFFFFF}, '{2'h1, ac, 8'h13, 32'hFFFFFFFF},
        '{2'h1, ar, 8'h3C, 32'hFFFF3CFF}, '{2'h1, ar, 8'hC3, 32'hFFFF3CC3}};

    logic clk_sys = 1'h0; // system clock
    logic rst_n = 1'h0; // reset, active low
    logic wr = 1'h0; // write strobe
    logic rd = 1'h0; // read strobe
    logic [7:0] addr = 8'h00; // address
    logic [7:0] wdata = 8'h00; // write data
    logic [7:0] rdata; // read data
    logic [31:0] result; // whole result
    int fail_count = 0; // mismatches
    int n_compared = 0; // comparisons

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    crcu_top uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SFR_ADDR(addr),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
        .CRC_RESULT(result));

    ////////////////////////////////////////////////////////////////////////
    // compare and report tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t result %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence: table back to back, then a reset after the table and a control read
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'h1;
        for (int i = 0; i < 36; i++) begin
            rd = rows[i].op[1];
            wr = !rows[i].op[1];
            addr = rows[i].addr;
            wdata = rows[i].data;
            @(posedge clk_sys);
            #1;
            if (rows[i].op == 2'h2) begin
                chk8(rdata, rows[i].exp[7:0]);
            end else if (rows[i].op == 2'h1) begin
                chk32(result, rows[i].exp);
            end
        end
        wr = 1'h0;
        rd = 1'h0;
        rst_n = 1'h0;
        @(posedge clk_sys);
        #1 rst_n = 1'h1;
        chk32(result, RESULT_RESET);
        chk8(rdata, RDATA_RESET);
        rd = 1'h1;
        addr = ac;
        @(posedge clk_sys);
        #1 rd = 1'h0;
        chk8(rdata, CTRL_RESET);
        finish_test();
    end
endmodule // tb_crc16_crc32_unit
`default_nettype wire
